// [rlc_gateway_codec.v]
// Gateway-side framer and deframer for the metering radio link
`timescale 1ns/1ps
`include "rlc_defines.vh"
// Summary of operation
// - One checksum covers the whole exchange frame
// - Exchange payload never exceeds 115 bytes
// - Control bit 5 always sent as zero
// - Data control priority bit: 0 low, 1 high
// - Reserved bit zero; primary bit marks initiator
// - Only ping, pong, data, command, response codes
// - Manufacturer and address always name the device
// - Control-information byte is always 0x20
// - Exchange length byte lies in 12..127
// - Field order length, control, manuf, address, CI
// - Address: serial LSB first, version, type
// - Exchange checksum two bytes, MSB first
// - Length 255 marks a download frame
// - Download: 218 payload, 4 header, 2 checksum
// - Data bytes first, then 32 parity bytes
// - Download sequence id three bytes, MSB first
// - Download checksum MSB first before parity
// - Parity covers sequence id through payload
// - One command and response per data message
module rlc_gateway_codec
(
   input wire clk,
   input wire sys_rst,
   input wire txStart,
   input wire [1:0] txKind,
   input wire [6:0] txPayLen,
   input wire [15:0] txManuf,
   input wire [47:0] txAddr,
   input wire [23:0] txSeqId,
   output wire txBusy,
   output reg txRefused_ff,
   output reg txDone_ff,
   input wire [7:0] txData,
   input wire txDataValid,
   output wire txDataReady,
   output reg [7:0] phyTxByte_ff,
   output reg phyTxValid_ff,
   input wire phyTxReady,
   input wire [7:0] phyRxByte,
   input wire phyRxValid,
   input wire phyRxSof,
   output wire phyRxReady,
   output wire [7:0] rxData,
   output wire rxDataValid,
   input wire rxDataReady,
   output reg rxDone_ff,
   output reg rxGood_ff,
   output reg [1:0] rxKind_ff,
   output reg rxPriority_ff,
   output reg [15:0] rxManuf_ff,
   output reg [47:0] rxAddr_ff,
   output reg rxLenErr_ff,
   output reg rxCtrlErr_ff,
   output reg rxCiErr_ff,
   output reg rxCrcErr_ff,
   output reg rxDownloadSeen_ff,
   output reg cmdArmed_ff
);
   localparam [4:0] ST_IDLE = 5'h01;
   localparam [4:0] ST_HDR = 5'h02;
   localparam [4:0] ST_PAY = 5'h04;
   localparam [4:0] ST_CRC = 5'h08;
   localparam [4:0] ST_PAR = 5'h10;

   // CRC update, MSB-first shift, zero start, complemented on the wire
   function [15:0] crcUpd;
      input [15:0] crc;
      input [7:0] d;
      integer i;
      reg [15:0] c;
      begin
         c = crc;
         for (i = 7; i >= 0; i = i - 1)
         begin
            if (c[15] ^ d[i])
               c = {c[14:0], 1'b0} ^ `RLC_CRC_POLY;
            else
               c = {c[14:0], 1'b0};
         end
         crcUpd = c;
      end
   endfunction

   // Header byte by index; exchange and download headers share the counter
   function [7:0] hdrByte;
      input dl;
      input [7:0] idx;
      input [7:0] lenVal;
      input [7:0] ctrl;
      input [15:0] manuf;
      input [47:0] addr;
      input [23:0] seq;
      begin
         if (dl)
         begin
            case (idx)
               8'h00: hdrByte = `RLC_LEN_DL;
               8'h01: hdrByte = seq[23:16];
               8'h02: hdrByte = seq[15:8];
               default: hdrByte = seq[7:0];
            endcase
         end
         else
         begin
            case (idx)
               8'h00: hdrByte = lenVal;
               8'h01: hdrByte = ctrl;
               8'h02: hdrByte = manuf[7:0];
               8'h03: hdrByte = manuf[15:8];
               8'h04: hdrByte = addr[7:0];
               8'h05: hdrByte = addr[15:8];
               8'h06: hdrByte = addr[23:16];
               8'h07: hdrByte = addr[31:24];
               8'h08: hdrByte = addr[39:32];
               8'h09: hdrByte = addr[47:40];
               default: hdrByte = `RLC_CI_APP;
            endcase
         end
      end
   endfunction

   // Transmit path
   reg [4:0] txState_ff;
   reg [7:0] txCnt_ff;
   reg [7:0] txPayN_ff;
   reg txDl_ff;
   reg [7:0] txCtrl_ff;
   reg [15:0] txManuf_ff;
   reg [47:0] txAddr_ff;
   reg [23:0] txSeq_ff;
   reg [15:0] txCrc_ff;
   reg cmdUse_ff;
   wire txAdv;
   wire [7:0] txHdrLast;
   wire [7:0] txLenByte;
   wire [7:0] txHdr;
   wire txTake;
   wire txBad;

   assign txAdv = ~phyTxValid_ff | phyTxReady;
   assign txBusy = (txState_ff != ST_IDLE);
   assign txHdrLast = txDl_ff ? `RLC_DL_HDR_LAST : `RLC_EX_HDR_LAST;
   assign txLenByte = txPayN_ff + `RLC_LEN_OVERHEAD;
   assign txHdr = hdrByte(txDl_ff, txCnt_ff, txLenByte, txCtrl_ff, txManuf_ff, txAddr_ff,
      txSeq_ff);
   assign txDataReady = txAdv & ((txState_ff == ST_PAY) | (txState_ff == ST_PAR));
   assign txTake = txDataReady & txDataValid;
   // Commands only after a data frame, once each; long payloads refused
   assign txBad = (txKind == `RLC_KIND_COMMAND && !cmdArmed_ff) ||
      (txKind != `RLC_KIND_DOWNLOAD && {1'b0, txPayLen} > `RLC_PAY_MAX) ||
      (txKind == 2'h3);

   always @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         txState_ff <= ST_IDLE;
         txCnt_ff <= 8'h00;
         txPayN_ff <= 8'h00;
         txDl_ff <= 1'b0;
         txCtrl_ff <= 8'h00;
         txManuf_ff <= 16'h0000;
         txAddr_ff <= 48'h000000000000;
         txSeq_ff <= 24'h000000;
         txCrc_ff <= `RLC_CRC_INIT;
         txRefused_ff <= 1'b0;
         txDone_ff <= 1'b0;
         phyTxByte_ff <= 8'h00;
         phyTxValid_ff <= 1'b0;
      end
      else
      begin
         txRefused_ff <= 1'b0;
         txDone_ff <= 1'b0;
         if (txAdv)
            phyTxValid_ff <= 1'b0;
         case (txState_ff)
            ST_IDLE:
            begin
               if (txStart & txBad)
                  txRefused_ff <= 1'b1;
               else if (txStart)
               begin
                  txState_ff <= ST_HDR;
                  txCnt_ff <= 8'h00;
                  txCrc_ff <= `RLC_CRC_INIT;
                  txDl_ff <= (txKind == `RLC_KIND_DOWNLOAD);
                  txPayN_ff <= (txKind == `RLC_KIND_DOWNLOAD) ? `RLC_DL_PAY : {1'b0, txPayLen};
                  // Gateway initiates commands, answers pings with cleared primary bit
                  txCtrl_ff <= (txKind == `RLC_KIND_COMMAND) ? `RLC_C_COMMAND : `RLC_C_PONG;
                  txManuf_ff <= txManuf;
                  txAddr_ff <= txAddr;
                  txSeq_ff <= txSeqId;
               end
            end
            ST_HDR:
            begin
               if (txAdv)
               begin
                  phyTxByte_ff <= txHdr;
                  phyTxValid_ff <= 1'b1;
                  txCrc_ff <= crcUpd(txCrc_ff, txHdr);
                  txCnt_ff <= txCnt_ff + 8'h01;
                  if (txCnt_ff == txHdrLast)
                  begin
                     txCnt_ff <= 8'h00;
                     txState_ff <= (txPayN_ff == 8'h00) ? ST_CRC : ST_PAY;
                  end
               end
            end
            ST_PAY:
            begin
               if (txTake)
               begin
                  phyTxByte_ff <= txData;
                  phyTxValid_ff <= 1'b1;
                  txCrc_ff <= crcUpd(txCrc_ff, txData);
                  txCnt_ff <= txCnt_ff + 8'h01;
                  if (txCnt_ff == txPayN_ff - 8'h01)
                  begin
                     txCnt_ff <= 8'h00;
                     txState_ff <= ST_CRC;
                  end
               end
            end
            ST_CRC:
            begin
               if (txAdv)
               begin
                  // High byte first, then low
                  phyTxByte_ff <= (txCnt_ff == 8'h00) ? ~txCrc_ff[15:8] : ~txCrc_ff[7:0];
                  phyTxValid_ff <= 1'b1;
                  txCnt_ff <= txCnt_ff + 8'h01;
                  if (txCnt_ff == 8'h01)
                  begin
                     txCnt_ff <= 8'h00;
                     txState_ff <= txDl_ff ? ST_PAR : ST_IDLE;
                     txDone_ff <= ~txDl_ff;
                  end
               end
            end
            ST_PAR:
            begin
               // Parity is computed upstream and streamed MSB first
               if (txTake)
               begin
                  phyTxByte_ff <= txData;
                  phyTxValid_ff <= 1'b1;
                  txCnt_ff <= txCnt_ff + 8'h01;
                  if (txCnt_ff == `RLC_DL_PARITY - 8'h01)
                  begin
                     txCnt_ff <= 8'h00;
                     txState_ff <= ST_IDLE;
                     txDone_ff <= 1'b1;
                  end
               end
            end
            default:
               txState_ff <= ST_IDLE;
         endcase
      end
   end

   // Receive path
   reg [4:0] rxState_ff;
   reg [7:0] rxCnt_ff;
   reg [7:0] rxPayN_ff;
   reg [15:0] rxCrc_ff;
   reg [7:0] rxCrcHi_ff;
   reg [7:0] rxCtrl_ff;
   reg rxBadCtrl_ff;
   reg rxBadCi_ff;
   wire bufInReady;
   wire rxTake;
   wire ctrlOk;
   wire pushPay;

   assign phyRxReady = (rxState_ff != ST_PAY) | bufInReady;
   assign rxTake = phyRxValid & phyRxReady;
   assign pushPay = rxTake & ~phyRxSof & (rxState_ff == ST_PAY);
   // Uplink codes only; reserved and bit 5 must read zero
   assign ctrlOk = (phyRxByte == `RLC_C_PING) || (phyRxByte == `RLC_C_DATA_LO) ||
      (phyRxByte == `RLC_C_DATA_HI) || (phyRxByte == `RLC_C_RESPONSE);

   rlc_buf2 uPayBuf
   (
      .clk(clk),
      .sys_rst(sys_rst),
      .inValid(pushPay),
      .inReady(bufInReady),
      .inData(phyRxByte),
      .outValid(rxDataValid),
      .outReady(rxDataReady),
      .outData(rxData)
   );

   always @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         rxState_ff <= ST_IDLE;
         rxCnt_ff <= 8'h00;
         rxPayN_ff <= 8'h00;
         rxCrc_ff <= `RLC_CRC_INIT;
         rxCrcHi_ff <= 8'h00;
         rxCtrl_ff <= 8'h00;
         rxBadCtrl_ff <= 1'b0;
         rxBadCi_ff <= 1'b0;
         rxDone_ff <= 1'b0;
         rxGood_ff <= 1'b0;
         rxKind_ff <= `RLC_RX_PING;
         rxPriority_ff <= 1'b0;
         rxManuf_ff <= 16'h0000;
         rxAddr_ff <= 48'h000000000000;
         rxLenErr_ff <= 1'b0;
         rxCtrlErr_ff <= 1'b0;
         rxCiErr_ff <= 1'b0;
         rxCrcErr_ff <= 1'b0;
         rxDownloadSeen_ff <= 1'b0;
         cmdArmed_ff <= 1'b0;
      end
      else
      begin
         rxDone_ff <= 1'b0;
         rxDownloadSeen_ff <= 1'b0;
         // A good data frame arms one command; rearm wins over sending it
         if (cmdUse_ff)
            cmdArmed_ff <= 1'b0;
         if (rxTake & phyRxSof)
         begin
            rxCrc_ff <= crcUpd(`RLC_CRC_INIT, phyRxByte);
            rxCnt_ff <= 8'h01;
            rxBadCtrl_ff <= 1'b0;
            rxBadCi_ff <= 1'b0;
            rxPayN_ff <= phyRxByte - `RLC_LEN_OVERHEAD;
            if (phyRxByte > `RLC_LEN_MAX)
            begin
               // Download frames are gateway-originated; flag and skip
               rxDownloadSeen_ff <= 1'b1;
               rxState_ff <= ST_IDLE;
            end
            else if (phyRxByte < `RLC_LEN_MIN)
            begin
               rxLenErr_ff <= 1'b1;
               // Status describes this frame only
               rxCtrlErr_ff <= 1'b0;
               rxCiErr_ff <= 1'b0;
               rxCrcErr_ff <= 1'b0;
               rxGood_ff <= 1'b0;
               rxDone_ff <= 1'b1;
               rxState_ff <= ST_IDLE;
            end
            else
            begin
               rxLenErr_ff <= 1'b0;
               rxState_ff <= ST_HDR;
            end
         end
         else if (rxTake)
         begin
            case (rxState_ff)
               ST_HDR:
               begin
                  rxCrc_ff <= crcUpd(rxCrc_ff, phyRxByte);
                  rxCnt_ff <= rxCnt_ff + 8'h01;
                  case (rxCnt_ff)
                     8'h01:
                     begin
                        rxCtrl_ff <= phyRxByte;
                        rxBadCtrl_ff <= ~ctrlOk;
                     end
                     8'h02: rxManuf_ff[7:0] <= phyRxByte;
                     8'h03: rxManuf_ff[15:8] <= phyRxByte;
                     8'h04: rxAddr_ff[7:0] <= phyRxByte;
                     8'h05: rxAddr_ff[15:8] <= phyRxByte;
                     8'h06: rxAddr_ff[23:16] <= phyRxByte;
                     8'h07: rxAddr_ff[31:24] <= phyRxByte;
                     8'h08: rxAddr_ff[39:32] <= phyRxByte;
                     8'h09: rxAddr_ff[47:40] <= phyRxByte;
                     default: rxBadCi_ff <= (phyRxByte != `RLC_CI_APP);
                  endcase
                  if (rxCnt_ff == `RLC_EX_HDR_LAST)
                  begin
                     rxCnt_ff <= 8'h00;
                     rxState_ff <= (rxPayN_ff == 8'h00) ? ST_CRC : ST_PAY;
                  end
               end
               ST_PAY:
               begin
                  rxCrc_ff <= crcUpd(rxCrc_ff, phyRxByte);
                  rxCnt_ff <= rxCnt_ff + 8'h01;
                  if (rxCnt_ff == rxPayN_ff - 8'h01)
                  begin
                     rxCnt_ff <= 8'h00;
                     rxState_ff <= ST_CRC;
                  end
               end
               ST_CRC:
               begin
                  rxCnt_ff <= rxCnt_ff + 8'h01;
                  if (rxCnt_ff == 8'h00)
                     rxCrcHi_ff <= phyRxByte;
                  else
                  begin
                     rxState_ff <= ST_IDLE;
                     rxDone_ff <= 1'b1;
                     rxCtrlErr_ff <= rxBadCtrl_ff;
                     rxCiErr_ff <= rxBadCi_ff;
                     rxCrcErr_ff <= ({rxCrcHi_ff, phyRxByte} != ~rxCrc_ff);
                     rxGood_ff <= ~rxBadCtrl_ff & ~rxBadCi_ff &
                        ({rxCrcHi_ff, phyRxByte} == ~rxCrc_ff);
                     rxPriority_ff <= rxCtrl_ff[`RLC_C_PRI_BIT];
                     if (rxCtrl_ff == `RLC_C_PING)
                        rxKind_ff <= `RLC_RX_PING;
                     else if (rxCtrl_ff == `RLC_C_RESPONSE)
                        rxKind_ff <= `RLC_RX_RESPONSE;
                     else
                        rxKind_ff <= `RLC_RX_DATA;
                     // Priority does not gate arming of the command window
                     if (~rxBadCtrl_ff & ~rxBadCi_ff & ({rxCrcHi_ff, phyRxByte} == ~rxCrc_ff) &&
                        rxCtrl_ff[`RLC_C_ZERO_BIT - 1] == 1'b0 &&
                        (rxCtrl_ff & 8'hef) == `RLC_C_DATA_LO)
                        cmdArmed_ff <= 1'b1;
                  end
               end
               default:
                  rxState_ff <= ST_IDLE;
            endcase
         end
      end
   end

   always @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         cmdUse_ff <= 1'b0;
      else
         cmdUse_ff <= txStart & ~txBad & (txState_ff == ST_IDLE) &
            (txKind == `RLC_KIND_COMMAND);
   end
endmodule // rlc_gateway_codec

// [rlc_defines.vh]
// Constants for the gateway-side radio link frame codec
`ifndef RLC_DEFINES_VH
`define RLC_DEFINES_VH
`define RLC_LEN_MIN 8'h0c
`define RLC_LEN_MAX 8'h7f
`define RLC_LEN_DL 8'hff
`define RLC_LEN_OVERHEAD 8'h0c
`define RLC_PAY_MAX 8'h73
`define RLC_DL_PAY 8'hda
`define RLC_DL_PARITY 8'h20
`define RLC_EX_HDR_LAST 8'h0a
`define RLC_DL_HDR_LAST 8'h03
`define RLC_CI_APP 8'h20
`define RLC_C_PING 8'h46
`define RLC_C_PONG 8'h06
`define RLC_C_DATA_LO 8'h44
`define RLC_C_DATA_HI 8'h54
`define RLC_C_COMMAND 8'h43
`define RLC_C_RESPONSE 8'h08
`define RLC_C_ZERO_BIT 6
`define RLC_C_PRI_BIT 4
`define RLC_CRC_POLY 16'h3d65
`define RLC_CRC_INIT 16'h0000
`define RLC_KIND_PONG 2'h0
`define RLC_KIND_COMMAND 2'h1
`define RLC_KIND_DOWNLOAD 2'h2
`define RLC_RX_PING 2'h0
`define RLC_RX_DATA 2'h1
`define RLC_RX_RESPONSE 2'h2
`endif

// [rlc_buf2.v]
// Two-entry valid/ready buffer for received payload bytes
`timescale 1ns/1ps
module rlc_buf2
(
   input wire clk,
   input wire sys_rst,
   input wire inValid,
   output wire inReady,
   input wire [7:0] inData,
   output wire outValid,
   input wire outReady,
   output wire [7:0] outData
);
   reg [7:0] mem_ff [0:1];
   reg wrIdx_ff;
   reg rdIdx_ff;
   reg [1:0] count_ff;
   wire push;
   wire pop;

   assign inReady = (count_ff != 2'h2);
   assign outValid = (count_ff != 2'h0);
   assign outData = mem_ff[rdIdx_ff];
   assign push = inValid & inReady;
   assign pop = outValid & outReady;

   always @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         mem_ff[0] <= 8'h00;
         mem_ff[1] <= 8'h00;
         wrIdx_ff <= 1'b0;
         rdIdx_ff <= 1'b0;
         count_ff <= 2'h0;
      end
      else
      begin
         if (push)
         begin
            mem_ff[wrIdx_ff] <= inData;
            wrIdx_ff <= ~wrIdx_ff;
         end
         if (pop)
            rdIdx_ff <= ~rdIdx_ff;
         if (push & ~pop)
            count_ff <= count_ff + 2'h1;
         else if (pop & ~push)
            count_ff <= count_ff - 2'h1;
      end
   end
endmodule // rlc_buf2

// [rlc_codec_properties.sv]
// Concurrent checks on the gateway codec ports
`timescale 1ns/1ps
module rlc_codec_properties
(
   input wire clk,
   input wire sys_rst,
   input wire txStart,
   input wire [1:0] txKind,
   input wire [6:0] txPayLen,
   input wire txBusy,
   input wire txRefused_ff,
   input wire [7:0] phyTxByte_ff,
   input wire phyTxValid_ff,
   input wire phyTxReady,
   input wire [7:0] phyRxByte,
   input wire phyRxValid,
   input wire phyRxSof,
   input wire phyRxReady,
   input wire rxDone_ff,
   input wire rxLenErr_ff,
   input wire rxDownloadSeen_ff,
   input wire cmdArmed_ff
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   sequence sTake;
      txStart && !txBusy;
   endsequence
   sequence sPong;
      sTake ##0 (txKind == 2'h0 && txPayLen <= 7'h73);
   endsequence
   sequence sLenByte;
      phyRxSof && phyRxValid && phyRxReady;
   endsequence
   a_refuse_bad_kind: assert property (sTake ##0 (txKind == 2'h3) |=> txRefused_ff)
      else $error("kind 3 taken");
   a_refuse_long_pay: assert property (
      sTake ##0 (txKind != 2'h2 && txPayLen > 7'h73) |=> txRefused_ff)
      else $error("long payload taken");
   a_pong_len_byte: assert property (sPong |-> ##2 phyTxValid_ff &&
      phyTxByte_ff == {1'b0, $past(txPayLen, 2)} + 8'h0c)
      else $error("length byte wrong");
   a_pong_ctrl_next: assert property (sPong ##2 (phyTxValid_ff && phyTxReady) |=>
      !phyTxValid_ff || phyTxByte_ff == 8'h06)
      else $error("reply ctrl wrong");
   a_dl_len_byte: assert property (
      sTake ##0 (txKind == 2'h2) |-> ##2 phyTxValid_ff && phyTxByte_ff == 8'hff)
      else $error("dl length wrong");
   a_tx_byte_holds: assert property (phyTxValid_ff && !phyTxReady |=>
      phyTxValid_ff && $stable(phyTxByte_ff))
      else $error("byte lost in stall");
   a_cmd_needs_arm: assert property (
      sTake ##0 (txKind == 2'h1 && !cmdArmed_ff) |=> txRefused_ff)
      else $error("unarmed command taken");
   a_cmd_disarms: assert property (
      sTake ##0 (txKind == 2'h1 && cmdArmed_ff && txPayLen <= 7'h73) |-> ##3 !cmdArmed_ff)
      else $error("permit kept");
   a_rx_len_error: assert property (
      sLenByte ##0 (phyRxByte < 8'h0c) |-> ##[1:3] (rxDone_ff && rxLenErr_ff))
      else $error("short length missed");
   a_rx_dl_flag: assert property (
      sLenByte ##0 (phyRxByte > 8'h7f) |-> ##[1:3] rxDownloadSeen_ff)
      else $error("dl length missed");
endmodule // rlc_codec_properties

bind rlc_gateway_codec rlc_codec_properties u_props (.*);

// [rlc_device_model.sv]
// Device-side partner model
`timescale 1ns/1ps
module rlc_device_model
(
   input wire clk,
   input wire [7:0] phyTxByte,
   input wire phyTxValid,
   output logic phyTxReady,
   output logic [7:0] phyRxByte,
   output logic phyRxValid,
   output logic phyRxSof,
   input wire phyRxReady
);
   logic [7:0] got[$];
   logic [7:0] pay[$];
   logic [7:0] frm[$];
   initial
   begin
      phyTxReady = 1'b1;
      phyRxByte = 8'h00;
      phyRxValid = 1'b0;
      phyRxSof = 1'b0;
   end
   // Random stalls test hold logic
   always @(negedge clk)
      phyTxReady <= $urandom_range(0, 3) != 0;
   always @(posedge clk)
      if (phyTxValid && phyTxReady)
         got.push_back(phyTxByte);
   function automatic logic [15:0] crc16(input int n);
      logic [15:0] c;
      c = 16'h0000;
      for (int i = 0; i < n; i++)
         for (int b = 7; b >= 0; b--)
            c = {c[14:0], 1'b0} ^ ((c[15] ^ frm[i][b]) ? 16'h3d65 : 16'h0000);
      return c;
   endfunction
   // Manufacturer and address are taken from the caller for each frame
   task automatic build(input logic [7:0] c, input logic [15:0] m, input logic [47:0] a,
      input logic [7:0] ci);
      logic [15:0] k;
      frm.delete();
      frm.push_back(8'(pay.size()) + 8'h0c);
      frm.push_back(c);
      for (int i = 0; i < 2; i++)
         frm.push_back(m[8*i +: 8]);
      for (int i = 0; i < 6; i++)
         frm.push_back(a[8*i +: 8]);
      frm.push_back(ci);
      foreach (pay[i])
         frm.push_back(pay[i]);
      k = ~crc16(frm.size());
      frm.push_back(k[15:8]);
      frm.push_back(k[7:0]);
   endtask
   task automatic send(input logic bad);
      for (int i = 0; i < frm.size(); i++)
      begin
         @(negedge clk);
         phyRxByte <= frm[i] ^ {7'h00, bad && i == frm.size() - 1};
         phyRxValid <= 1'b1;
         phyRxSof <= i == 0;
         #1;
         while (!phyRxReady)
         begin
            @(negedge clk);
            #1;
         end
         @(posedge clk);
      end
      @(negedge clk);
      phyRxValid <= 1'b0;
      phyRxSof <= 1'b0;
      phyRxByte <= ~phyRxByte;
   endtask
endmodule // rlc_device_model

// [test_rlc_gateway_codec.sv]
// Self-checking bench for the gateway codec against a device model
`timescale 1ns/1ps
module test_rlc_gateway_codec;
   logic clk, sys_rst, txStart, txBusy, txRefused, txDone, txDataValid, txDataReady;
   logic [1:0] txKind, rxKind;
   logic [6:0] txPayLen;
   logic [15:0] txManuf, rxManuf;
   logic [47:0] txAddr, rxAddr;
   logic [23:0] txSeqId;
   logic [7:0] txData, phyTxByte, phyRxByte, rxData;
   logic phyTxValid, phyTxReady, phyRxValid, phyRxSof, phyRxReady, rxDataValid, rxDataReady;
   logic rxDone, rxGood, rxPriority, rxLenErr, rxCtrlErr, rxCiErr, rxCrcErr, rxDlSeen, cmdArmed;
   logic [7:0] txq[$];
   logic [7:0] rq[$];
   logic [7:0] codes[4] = '{8'h44, 8'h54, 8'h46, 8'h08};
   logic [1:0] kinds[4] = '{2'h1, 2'h1, 2'h0, 2'h2};
   int num_errors = 0;
   int compares = 0;
   int cyc = 0;
   rlc_gateway_codec u_dut (.clk(clk), .sys_rst(sys_rst), .txStart(txStart), .txKind(txKind),
      .txPayLen(txPayLen), .txManuf(txManuf), .txAddr(txAddr), .txSeqId(txSeqId),
      .txBusy(txBusy), .txRefused_ff(txRefused), .txDone_ff(txDone), .txData(txData),
      .txDataValid(txDataValid), .txDataReady(txDataReady), .phyTxByte_ff(phyTxByte),
      .phyTxValid_ff(phyTxValid), .phyTxReady(phyTxReady), .phyRxByte(phyRxByte),
      .phyRxValid(phyRxValid), .phyRxSof(phyRxSof), .phyRxReady(phyRxReady), .rxData(rxData),
      .rxDataValid(rxDataValid), .rxDataReady(rxDataReady), .rxDone_ff(rxDone),
      .rxGood_ff(rxGood), .rxKind_ff(rxKind), .rxPriority_ff(rxPriority), .rxManuf_ff(rxManuf),
      .rxAddr_ff(rxAddr), .rxLenErr_ff(rxLenErr), .rxCtrlErr_ff(rxCtrlErr),
      .rxCiErr_ff(rxCiErr), .rxCrcErr_ff(rxCrcErr), .rxDownloadSeen_ff(rxDlSeen),
      .cmdArmed_ff(cmdArmed));
   rlc_device_model u_dev (.clk(clk), .phyTxByte(phyTxByte), .phyTxValid(phyTxValid),
      .phyTxReady(phyTxReady), .phyRxByte(phyRxByte), .phyRxValid(phyRxValid),
      .phyRxSof(phyRxSof), .phyRxReady(phyRxReady));
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 60000)
      begin
         num_errors++;
         tally_and_finish();
      end
   end
   always @(negedge clk)
   begin
      txDataValid <= txq.size() > 0;
      txData <= (txq.size() > 0) ? txq[0] : ~txData;
      rxDataReady <= $urandom_range(0, 2) != 0;
   end
   always @(posedge clk)
   begin
      if (txDataValid && txDataReady)
         void'(txq.pop_front());
      if (rxDataValid && rxDataReady)
         rq.push_back(rxData);
   end
   task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
      compares++;
      if (got !== exp)
      begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic tally_and_finish();
      if (num_errors == 0 && compares > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic randPay(input int n);
      u_dev.pay.delete();
      repeat (n) u_dev.pay.push_back(8'($urandom));
   endtask
   task automatic request(input logic [1:0] k, input logic [6:0] n, input logic refuse);
      logic [7:0] par[$];
      int t;
      u_dev.got.delete();
      randPay(k == 2'h2 ? 218 : int'(n));
      repeat (32) par.push_back(8'($urandom));
      @(negedge clk);
      if (!refuse)
         txq = (k == 2'h2) ? {u_dev.pay, par} : u_dev.pay;
      txKind = k;
      txPayLen = n;
      txManuf = 16'($urandom);
      txAddr = {16'($urandom), 32'($urandom)};
      txSeqId = 24'($urandom);
      txStart = 1'b1;
      @(negedge clk);
      txStart = 1'b0;
      chk("txRefused", refuse, txRefused);
      if (refuse)
         return;
      t = 0;
      while (txDone !== 1'b1 && t < 3000)
      begin
         @(negedge clk);
         t++;
      end
      chk("txDone", 1, txDone);
      while (phyTxValid === 1'b1)
         @(negedge clk);
      if (k == 2'h2)
      begin
         chk("dlSize", 256, u_dev.got.size());
         chk("dlLen", 8'hff, u_dev.got[0]);
         chk("dlSeq", txSeqId, {u_dev.got[1], u_dev.got[2], u_dev.got[3]});
         for (int i = 0; i < 218; i++)
            chk("dlPay", u_dev.pay[i], u_dev.got[4 + i]);
         for (int i = 0; i < 32; i++)
            chk("dlParity", par[i], u_dev.got[224 + i]);
      end
      else
      begin
         u_dev.build(k == 2'h1 ? 8'h43 : 8'h06, txManuf, txAddr, 8'h20);
         chk("txSize", u_dev.frm.size(), u_dev.got.size());
         foreach (u_dev.frm[i])
            chk("txByte", u_dev.frm[i], u_dev.got[i]);
      end
   endtask
   // Non-zero lone: a bare length byte
   task automatic recv(input logic [7:0] c, ci, lone, input logic bad, input logic [1:0] kind,
      input logic [3:0] err);
      logic [15:0] m;
      logic [47:0] a;
      int t;
      m = 16'($urandom);
      a = {16'($urandom), 32'($urandom)};
      randPay($urandom_range(0, 115));
      u_dev.build(c, m, a, ci);
      if (lone != 8'h00)
         u_dev.frm = {lone};
      rq.delete();
      u_dev.send(bad);
      t = 0;
      while (rxDone !== 1'b1 && rxDlSeen !== 1'b1 && t < 50)
      begin
         @(negedge clk);
         t++;
      end
      if (lone > 8'h7f)
         chk("rxDlSeen", 1, rxDlSeen);
      else
      begin
         chk("rxFlags", err, {rxLenErr, rxCtrlErr, rxCiErr, rxCrcErr});
         chk("rxGood", err == 4'h0, rxGood);
      end
      repeat (8) @(negedge clk);
      if (err == 4'h0 && lone == 8'h00)
      begin
         chk("rxKind", kind, rxKind);
         chk("rxId", {m, a}, {rxManuf, rxAddr});
         if (kind == 2'h1)
            chk("rxPriority", c[4], rxPriority);
         chk("rxCount", u_dev.pay.size(), rq.size());
         foreach (rq[i])
            chk("rxData", u_dev.pay[i], rq[i]);
      end
   endtask
   initial
   begin
      sys_rst = 1'b1;
      txStart = 1'b0;
      txKind = 2'h0;
      txPayLen = 7'h00;
      txData = 8'h00;
      txDataValid = 1'b0;
      rxDataReady = 1'b0;
      void'($urandom(32'hf13172d0));
      repeat (2) @(posedge clk);
      @(negedge clk);
      sys_rst = 1'b0;
      request(2'h1, 7'h05, 1'b1);
      request(2'h3, 7'h00, 1'b1);
      request(2'h0, 7'h74, 1'b1);
      request(2'h0, 7'h00, 1'b0);
      request(2'h0, 7'h73, 1'b0);
      recv(8'h44, 8'h20, 8'h00, 1'b0, 2'h1, 4'h0);
      request(2'h1, 7'($urandom_range(0, 115)), 1'b0);
      request(2'h1, 7'h03, 1'b1);
      request(2'h2, 7'h00, 1'b0);
      for (int i = 0; i < 4; i++)
         recv(codes[i], 8'h20, 8'h00, 1'b0, kinds[i], 4'h0);
      recv(8'h44, 8'h20, 8'h00, 1'b1, 2'h1, 4'h1);
      recv(8'h44, 8'h21, 8'h00, 1'b0, 2'h1, 4'h2);
      recv(8'h64, 8'h20, 8'h00, 1'b0, 2'h1, 4'h4);
      recv(8'h45, 8'h20, 8'h00, 1'b0, 2'h1, 4'h4);
      recv(8'h44, 8'h20, 8'h0b, 1'b0, 2'h1, 4'h8);
      recv(8'h44, 8'h20, 8'hc8, 1'b0, 2'h1, 4'h0);
      recv(8'h44, 8'h20, 8'hff, 1'b0, 2'h1, 4'h0);
      repeat (4)
      begin
         recv(8'h54, 8'h20, 8'h00, 1'b0, 2'h1, 4'h0);
         request(2'h1, 7'($urandom_range(0, 115)), 1'b0);
      end
      tally_and_finish();
   end
endmodule // test_rlc_gateway_codec
